// [include/reset_a20_consts.vh]
// Purpose: shared constants for the reset source and address-20 gate block
// Assumes: included by bare name from the core files
// Notes: offsets are byte addresses on their own access paths
`ifndef RESET_A20_CONSTS_VH
`define RESET_A20_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// direct-mapped i/o port addresses
`define IO_LEGACY_DATA_ADDR 16'h0060
`define IO_LEGACY_CMD_ADDR 16'h0064
`define IO_FAST_CTL_ADDR 16'h0092

////////////////////////////////////////////////////////////////////////////////
// memory-mapped configuration offsets
`define MMCR_RESET_CFG_ADDR 12'hD72
`define MMCR_RESET_STATUS_ADDR 12'hD74

////////////////////////////////////////////////////////////////////////////////
// reset_configuration field positions
`define CFG_SOFTWARE_SYSTEM_RESET_BIT 0
`define CFG_PERIPHERAL_BUS_RESET_BIT_BIT 1
`define CFG_PRESERVE_ENB_BIT 2
`define CFG_RESET_VAL 8'h00

////////////////////////////////////////////////////////////////////////////////
// reset_source_status field positions
`define STA_POWER_OK_BIT 0
`define STA_PROG_PIN_BIT 1
`define STA_SHUTDOWN_BIT 2
`define STA_WATCHDOG_BIT 3
`define STA_DEBUG_SYS_BIT 4
`define STA_DEBUG_HARD_BIT 5
`define STA_LEGACY_CMD_BIT 6
`define STA_FLAG_COUNT 7
`define STA_RESET_VAL 8'h01

////////////////////////////////////////////////////////////////////////////////
// fast_system_control_port fields
`define FAST_CPU_RST_BIT 0
`define FAST_ADDR20_BIT 1
`define FAST_RESET_VAL 8'h00

////////////////////////////////////////////////////////////////////////////////
// legacy controller emulation
`define LEGACY_GATE_BIT 1
`define LEGACY_GATE_RESET 1'h1
`define LEGACY_CMD_WRITE_OUT 8'hD1
`define LEGACY_CMD_CPU_RESET 8'hFE

////////////////////////////////////////////////////////////////////////////////
// hard reset stretch, in clk_sys_in cycles
`define HARD_RESET_CYCLES 8'h10

`endif

// [core/status_flag.v]
// Purpose: one sticky status flag, set by hardware, cleared by writing 1
// Assumes: set_in and clr_in are synchronous one-cycle strobes
// Notes: only rst_in and restore_in (power-good) return the flag to RESET_VAL

module status_flag #(
  parameter [0:0] RESET_VAL = 1'h0
) (
  input wire clk_sys_in,
  input wire rst_in,
  input wire restore_in,
  input wire set_in,
  input wire clr_in,
  output wire flag_out
);

  reg flag_ff;
  reg nxt_flag;

  // restore first, then set beats a same-cycle clear
  always @*
  begin
    if (restore_in)
      nxt_flag = RESET_VAL;
    else if (set_in)
      nxt_flag = 1'h1;
    else if (clr_in)
      nxt_flag = 1'h0;
    else
      nxt_flag = flag_ff;
  end

  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      flag_ff <= RESET_VAL;
    else
      flag_ff <= nxt_flag;
  end

  assign flag_out = flag_ff;

endmodule

// [core/reset_source_and_a20_emulation.v]
// Purpose: reset source capture, reset routing and legacy address-20 emulation
// Assumes: all inputs synchronous to clk_sys_in; i/o and mmcr strobes last one cycle
// Notes: rst_in stands for the power-on event and restores every register

`include "reset_a20_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module reset_source_and_a20_emulation (
  input wire clk_sys_in,
  input wire rst_in,
  input wire power_ok_pin_in,
  input wire preserving_reset_pin_in,
  input wire shutdown_cycle_in,
  input wire watchdog_reset_in,
  input wire debug_sys_reset_in,
  input wire host_bridge_pci_reset_in,
  input wire [15:0] io_addr_in,
  input wire io_wr_in,
  input wire io_rd_in,
  input wire [7:0] io_wdata_in,
  output wire [7:0] io_rdata_out,
  output wire io_gp_forward_out,
  input wire [11:0] mmcr_addr_in,
  input wire mmcr_wr_in,
  input wire mmcr_rd_in,
  input wire [7:0] mmcr_wdata_in,
  output wire [7:0] mmcr_rdata_out,
  output wire cpu_hard_reset_out,
  output wire cpu_soft_reset_out,
  output wire nonmaskable_irq_clear_out,
  output wire peripheral_bus_reset_pin_out,
  output wire pci_reset_out,
  output wire internal_reg_reset_out,
  output wire sdram_preserve_out,
  output wire addr20_mask_signal_out
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers

  // one decoder shared by every i/o write and read path
  function io_hit;
    input [15:0] addr;
    input [15:0] port;
    begin
      io_hit = (addr == port);
    end
  endfunction

  function mmcr_hit;
    input [11:0] addr;
    input [11:0] offs;
    begin
      mmcr_hit = (addr == offs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  wire power_bad;
  wire wr_data_port;
  wire wr_cmd_port;
  wire wr_fast_port;
  wire rd_fast_port;
  wire wr_cfg;
  wire wr_sta;
  wire cfg_sel;
  wire sta_sel;
  wire prog_pin_event;
  wire sys_bit_event;
  wire wd_event;
  wire dbg_event;
  wire hard_event;
  wire hard_active;
  wire fast_rst_req;
  wire legacy_rst_req;
  wire shutdown_req;
  wire soft_req;
  wire [`STA_FLAG_COUNT-1:0] sta_set;
  wire [`STA_FLAG_COUNT-1:0] sta_clr;
  wire [`STA_FLAG_COUNT-1:0] sta_flags;
  wire [7:0] cfg_rd_value;
  localparam [7:0] sta_reset_bits = `STA_RESET_VAL; // one bit per flag instance

  reg [7:0] cfg_ff;
  reg [7:0] nxt_cfg;
  reg [7:0] fast_ctl_ff;
  reg [7:0] nxt_fast_ctl;
  reg emulated_addr20_gate_ff;
  reg nxt_emulated_addr20_gate;
  reg write_out_pending_ff;
  reg nxt_write_out_pending;
  reg prog_pin_d_ff;
  reg shutdown_d_ff;
  reg [7:0] hard_hold_ff;
  reg [7:0] nxt_hard_hold;
  reg preserve_ff;
  reg nxt_preserve;
  reg soft_pulse_ff;
  reg [7:0] io_rdata_ff;
  reg [7:0] nxt_io_rdata;
  reg [7:0] mmcr_rdata_ff;
  reg [7:0] nxt_mmcr_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // access strobes

  // power_ok low is itself the power-good reset
  assign power_bad = ~power_ok_pin_in;

  assign wr_data_port = io_wr_in & io_hit(io_addr_in, `IO_LEGACY_DATA_ADDR);
  assign wr_cmd_port = io_wr_in & io_hit(io_addr_in, `IO_LEGACY_CMD_ADDR);
  assign wr_fast_port = io_wr_in & io_hit(io_addr_in, `IO_FAST_CTL_ADDR);
  assign rd_fast_port = io_rd_in & io_hit(io_addr_in, `IO_FAST_CTL_ADDR);
  assign cfg_sel = mmcr_hit(mmcr_addr_in, `MMCR_RESET_CFG_ADDR);
  assign sta_sel = mmcr_hit(mmcr_addr_in, `MMCR_RESET_STATUS_ADDR);
  assign wr_cfg = mmcr_wr_in & cfg_sel;
  assign wr_sta = mmcr_wr_in & sta_sel;

  // data and command ports hold nothing; every access goes out to the GP bus
  assign io_gp_forward_out = (io_wr_in | io_rd_in) &
    (io_hit(io_addr_in, `IO_LEGACY_DATA_ADDR) |
     io_hit(io_addr_in, `IO_LEGACY_CMD_ADDR));

  ////////////////////////////////////////////////////////////////////////////
  // hard reset sources

  // pin counts once per assertion, and only while enabled with power good
  assign prog_pin_event = preserving_reset_pin_in & ~prog_pin_d_ff &
    cfg_ff[`CFG_PRESERVE_ENB_BIT] & ~power_bad;
  assign sys_bit_event = wr_cfg & mmcr_wdata_in[`CFG_SOFTWARE_SYSTEM_RESET_BIT];
  assign wd_event = watchdog_reset_in & ~power_bad;
  assign dbg_event = debug_sys_reset_in & ~power_bad;
  assign hard_event = prog_pin_event | sys_bit_event | wd_event | dbg_event;
  assign hard_active = power_bad | (hard_hold_ff != 8'h00);

  // edge memories for level sources
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prog_pin_d_ff <= 1'h0;
      shutdown_d_ff <= 1'h0;
    end
    else
    begin
      prog_pin_d_ff <= preserving_reset_pin_in;
      shutdown_d_ff <= shutdown_cycle_in;
    end
  end

  // stretch each hard event; power-good reset holds until power returns
  always @*
  begin
    nxt_hard_hold = hard_hold_ff;
    nxt_preserve = preserve_ff;
    if (power_bad)
    begin
      nxt_hard_hold = `HARD_RESET_CYCLES;
      nxt_preserve = 1'h0;
    end
    else if (hard_event)
    begin
      nxt_hard_hold = `HARD_RESET_CYCLES;
      // same-write enable counts for the software bit
      nxt_preserve = prog_pin_event | (sys_bit_event ?
        mmcr_wdata_in[`CFG_PRESERVE_ENB_BIT] : cfg_ff[`CFG_PRESERVE_ENB_BIT]);
    end
    else if (hard_hold_ff != 8'h00)
      nxt_hard_hold = hard_hold_ff - 8'h01;
    else
      nxt_preserve = 1'h0;
  end

  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hard_hold_ff <= `HARD_RESET_CYCLES;
      preserve_ff <= 1'h0;
    end
    else
    begin
      hard_hold_ff <= nxt_hard_hold;
      preserve_ff <= nxt_preserve;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset configuration register

  // kept across every reset but power-good
  always @*
  begin
    nxt_cfg = cfg_ff;
    if (power_bad)
      nxt_cfg = `CFG_RESET_VAL;
    else if (wr_cfg)
    begin
      nxt_cfg = 8'h00;
      nxt_cfg[`CFG_SOFTWARE_SYSTEM_RESET_BIT] = mmcr_wdata_in[`CFG_SOFTWARE_SYSTEM_RESET_BIT];
      nxt_cfg[`CFG_PERIPHERAL_BUS_RESET_BIT_BIT] = mmcr_wdata_in[`CFG_PERIPHERAL_BUS_RESET_BIT_BIT];
      nxt_cfg[`CFG_PRESERVE_ENB_BIT] = mmcr_wdata_in[`CFG_PRESERVE_ENB_BIT];
    end
  end

  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      cfg_ff <= `CFG_RESET_VAL;
    else
      cfg_ff <= nxt_cfg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft reset sources

  // any write of 1, even over a stale 1, requests a soft reset
  assign fast_rst_req = wr_fast_port & io_wdata_in[`FAST_CPU_RST_BIT];
  assign legacy_rst_req = wr_cmd_port &
    (io_wdata_in == `LEGACY_CMD_CPU_RESET);
  assign shutdown_req = shutdown_cycle_in & ~shutdown_d_ff;
  // a soft request inside a hard reset is swallowed by it
  assign soft_req = (fast_rst_req | legacy_rst_req | shutdown_req) &
    ~hard_active;

  // one registered cycle per request
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      soft_pulse_ff <= 1'h0;
    else
      soft_pulse_ff <= soft_req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fast system control port

  // internal register: cleared by any hard reset; reset bit stays until 0 written
  always @*
  begin
    nxt_fast_ctl = fast_ctl_ff;
    if (hard_active)
      nxt_fast_ctl = `FAST_RESET_VAL;
    else if (wr_fast_port)
    begin
      nxt_fast_ctl = 8'h00;
      nxt_fast_ctl[`FAST_ADDR20_BIT] = io_wdata_in[`FAST_ADDR20_BIT];
      nxt_fast_ctl[`FAST_CPU_RST_BIT] = io_wdata_in[`FAST_CPU_RST_BIT];
    end
  end

  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      fast_ctl_ff <= `FAST_RESET_VAL;
    else
      fast_ctl_ff <= nxt_fast_ctl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // legacy controller snoop

  // D1h arms the next data write; any other command disarms it
  always @*
  begin
    nxt_write_out_pending = write_out_pending_ff;
    nxt_emulated_addr20_gate = emulated_addr20_gate_ff;
    if (hard_active)
    begin
      nxt_write_out_pending = 1'h0;
      nxt_emulated_addr20_gate = `LEGACY_GATE_RESET;
    end
    else if (wr_cmd_port)
      nxt_write_out_pending = (io_wdata_in == `LEGACY_CMD_WRITE_OUT);
    else if (wr_data_port & write_out_pending_ff)
    begin
      nxt_write_out_pending = 1'h0;
      // bit 0 is ignored on purpose, it never holds the cpu in reset
      nxt_emulated_addr20_gate = io_wdata_in[`LEGACY_GATE_BIT];
    end
  end

  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      write_out_pending_ff <= 1'h0;
      emulated_addr20_gate_ff <= `LEGACY_GATE_RESET;
    end
    else
    begin
      write_out_pending_ff <= nxt_write_out_pending;
      emulated_addr20_gate_ff <= nxt_emulated_addr20_gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset source status flags

  assign sta_set[`STA_POWER_OK_BIT] = 1'h0;
  assign sta_set[`STA_PROG_PIN_BIT] = prog_pin_event;
  assign sta_set[`STA_SHUTDOWN_BIT] = shutdown_req & ~hard_active;
  assign sta_set[`STA_WATCHDOG_BIT] = wd_event;
  assign sta_set[`STA_DEBUG_SYS_BIT] = dbg_event;
  // no debug hard reset source reaches this block
  assign sta_set[`STA_DEBUG_HARD_BIT] = 1'h0;
  assign sta_set[`STA_LEGACY_CMD_BIT] = legacy_rst_req & ~hard_active;

  // power-good restore leaves bit 0 set, which records that source
  genvar gi;
  generate
    for (gi = 0; gi < `STA_FLAG_COUNT; gi = gi + 1)
    begin : g_flag
      assign sta_clr[gi] = wr_sta & mmcr_wdata_in[gi];
      status_flag #(
        .RESET_VAL(sta_reset_bits[gi])
      ) u_flag (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .restore_in(power_bad),
        .set_in(sta_set[gi]),
        .clr_in(sta_clr[gi]),
        .flag_out(sta_flags[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // gp reset bit reads back the pin itself
  assign cfg_rd_value = {5'h00, cfg_ff[`CFG_PRESERVE_ENB_BIT],
    peripheral_bus_reset_pin_out, cfg_ff[`CFG_SOFTWARE_SYSTEM_RESET_BIT]};

  // unmapped offsets read zero
  always @*
  begin
    nxt_mmcr_rdata = 8'h00;
    if (mmcr_rd_in & cfg_sel)
      nxt_mmcr_rdata = cfg_rd_value;
    else if (mmcr_rd_in & sta_sel)
      nxt_mmcr_rdata = {1'h0, sta_flags};
  end

  // only the fast port answers locally; 0060h/0064h reads come from GP bus
  always @*
  begin
    nxt_io_rdata = 8'h00;
    if (rd_fast_port)
      nxt_io_rdata = fast_ctl_ff;
  end

  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mmcr_rdata_ff <= 8'h00;
      io_rdata_ff <= 8'h00;
    end
    else
    begin
      mmcr_rdata_ff <= nxt_mmcr_rdata;
      io_rdata_ff <= nxt_io_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign mmcr_rdata_out = mmcr_rdata_ff;
  assign io_rdata_out = io_rdata_ff;
  assign cpu_hard_reset_out = hard_active;
  assign internal_reg_reset_out = hard_active;
  assign peripheral_bus_reset_pin_out = hard_active | cfg_ff[`CFG_PERIPHERAL_BUS_RESET_BIT_BIT];
  assign pci_reset_out = hard_active | host_bridge_pci_reset_in;
  assign sdram_preserve_out = preserve_ff & ~power_bad;
  assign cpu_soft_reset_out = soft_pulse_ff;
  // soft reset knocks out nmi enable so the stack can be set up first
  assign nonmaskable_irq_clear_out = soft_pulse_ff;
  // high masks address 20; either gate source lets it through
  assign addr20_mask_signal_out = ~(emulated_addr20_gate_ff |
    fast_ctl_ff[`FAST_ADDR20_BIT]);

endmodule

// [tb/reset_source_and_a20_emulation_props.sv]
// Purpose: timing relations at the ports of the reset and address-20 block
// Assumes: one clock domain, rst_in asynchronous active high
// Notes: attached by bind at the foot of this file
`include "reset_a20_consts.vh"

module rsa_props (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic power_ok_pin_in,
  input wire logic watchdog_reset_in,
  input wire logic host_bridge_pci_reset_in,
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic io_gp_forward_out,
  input wire logic cpu_hard_reset_out,
  input wire logic cpu_soft_reset_out,
  input wire logic nonmaskable_irq_clear_out,
  input wire logic pci_reset_out,
  input wire logic internal_reg_reset_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  ////////////////////////////////////////////////////////////////////////////
  // soft reset requests, each honoured only outside a hard reset
  AST_SOFT_ONE_CYCLE: assert property (cpu_soft_reset_out |=> !cpu_soft_reset_out)
    else $error("soft reset pulse longer than one cycle");
  AST_NMI_WITH_SOFT: assert property (nonmaskable_irq_clear_out == cpu_soft_reset_out)
    else $error("nmi enable clear not aligned with soft reset");
  AST_FAST_BIT_SOFT: assert property (io_wr_in && io_addr_in == `IO_FAST_CTL_ADDR
    && io_wdata_in[0] && !cpu_hard_reset_out |=> cpu_soft_reset_out)
    else $error("fast port reset bit gave no soft reset");
  AST_CMD_FE_SOFT: assert property (io_wr_in && io_addr_in == `IO_LEGACY_CMD_ADDR
    && io_wdata_in == 8'hFE && !cpu_hard_reset_out |=> cpu_soft_reset_out)
    else $error("reset command gave no soft reset");
  AST_SOFT_NOT_HARD: assert property (cpu_soft_reset_out |-> !cpu_hard_reset_out)
    else $error("soft reset came with a hard reset");

  ////////////////////////////////////////////////////////////////////////////
  // hard reset routing
  AST_INTERNAL_IS_HARD: assert property (internal_reg_reset_out == cpu_hard_reset_out)
    else $error("internal reset differs from cpu hard reset");
  AST_PCI_ROUTE: assert property (pci_reset_out ==
    (cpu_hard_reset_out | host_bridge_pci_reset_in))
    else $error("pci reset not hard reset or bridge bit");
  AST_WATCHDOG_HARD: assert property (watchdog_reset_in |=> cpu_hard_reset_out [*8])
    else $error("watchdog did not hold hard reset");
  AST_POWER_BAD_HARD: assert property (!power_ok_pin_in |=> cpu_hard_reset_out)
    else $error("power bad gave no hard reset");

  ////////////////////////////////////////////////////////////////////////////
  // legacy ports forwarded, fast port reserved bits read zero
  AST_FORWARD: assert property (io_gp_forward_out == ((io_wr_in || io_rd_in) &&
    (io_addr_in == `IO_LEGACY_DATA_ADDR || io_addr_in == `IO_LEGACY_CMD_ADDR)))
    else $error("legacy port access not forwarded");
  AST_FAST_RSV_ZERO: assert property (io_rd_in && io_addr_in == `IO_FAST_CTL_ADDR
    |=> io_rdata_out[7:2] == 6'h00)
    else $error("fast port reserved bits not zero");
endmodule

bind reset_source_and_a20_emulation rsa_props i_props (.*);

// [tb/cpu_core_model.sv]
// Purpose: cpu core side that receives soft reset and hard reset
// Assumes: soft reset arrives as a level sampled on the system clock
// Notes: counts high cycles; a real core would restart, this one only keeps score
module cpu_core_model (
  input wire logic clk_sys_in,
  input wire logic hard_in,
  input wire logic soft_in,
  output int soft_seen,
  output int soft_bad
);
  timeunit 1ns;
  timeprecision 100ps;
  initial soft_seen = 0;
  initial soft_bad = 0;

  // each sampled high cycle counts, so a stretched pulse shows as extra resets
  always @(posedge clk_sys_in)
  begin
    if (soft_in === 1'b1)
      soft_seen <= soft_seen + 1;
    if (soft_in === 1'b1 && hard_in === 1'b1)
      soft_bad <= soft_bad + 1;
  end
endmodule

// [tb/reset_source_and_a20_emulation_tb_top.sv]
// Purpose: self-checking bench for reset capture, routing and a20 emulation
// Assumes: inputs change 1 ns after the rising edge
// Notes: software keeps the fast reset bit at 0 when it changes the gate
`include "reset_a20_consts.vh"

module reset_source_and_a20_emulation_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic pok = 1'b1, prg = 1'b0, sdn = 1'b0, wd = 1'b0, dbg = 1'b0, pci = 1'b0;
  logic iw = 1'b0, ir = 1'b0, mw = 1'b0, mr = 1'b0;
  logic [15:0] ia = 16'h0000;
  logic [11:0] ma = 12'h000;
  logic [7:0] iwd = 8'h00, mwd = 8'h00, g, e;
  wire [7:0] ird, mrd;
  wire fwd, hrd, sft, nmi, pbr, prst, irr, sdp, msk;
  int soft_seen, soft_bad, err_total = 0, checks_done = 0, cyc = 0, n, s0;

  initial forever #25 clk_sys_in = ~clk_sys_in;

  reset_source_and_a20_emulation i_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .power_ok_pin_in(pok),
    .preserving_reset_pin_in(prg), .shutdown_cycle_in(sdn), .watchdog_reset_in(wd),
    .debug_sys_reset_in(dbg), .host_bridge_pci_reset_in(pci), .io_addr_in(ia),
    .io_wr_in(iw), .io_rd_in(ir), .io_wdata_in(iwd), .io_rdata_out(ird),
    .io_gp_forward_out(fwd), .mmcr_addr_in(ma), .mmcr_wr_in(mw), .mmcr_rd_in(mr),
    .mmcr_wdata_in(mwd), .mmcr_rdata_out(mrd), .cpu_hard_reset_out(hrd),
    .cpu_soft_reset_out(sft), .nonmaskable_irq_clear_out(nmi),
    .peripheral_bus_reset_pin_out(pbr), .pci_reset_out(prst),
    .internal_reg_reset_out(irr), .sdram_preserve_out(sdp), .addr20_mask_signal_out(msk));

  cpu_core_model i_cpu (.clk_sys_in(clk_sys_in), .hard_in(hrd), .soft_in(sft),
    .soft_seen(soft_seen), .soft_bad(soft_bad));

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask

  // one i/o access; forwarding is judged in the strobe cycle
  task automatic io(input logic [15:0] a, input logic [7:0] d, input logic rd);
    tick(1);
    ia = a;
    iwd = d;
    iw = !rd;
    ir = rd;
    // forward flag is combinational, let it settle before looking
    #1;
    chk(fwd, a == `IO_LEGACY_DATA_ADDR || a == `IO_LEGACY_CMD_ADDR);
    tick(1);
    iw = 1'b0;
    ir = 1'b0;
  endtask

  task automatic mm(input logic [11:0] a, input logic [7:0] d, input logic rd);
    tick(1);
    ma = a;
    mwd = d;
    mw = !rd;
    mr = rd;
    tick(1);
    mw = 1'b0;
    mr = 1'b0;
  endtask

  // bounded wait for the hard reset stretch; n holds its length
  task automatic hard_len;
    n = 0;
    while (hrd === 1'b1 && n < 40)
    begin
      n++;
      tick(1);
    end
  endtask

  // hang guard, the run needs well under a thousand cycles
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    s0 = $urandom(32'h4fb13387);
    tick(3);
    rst_in = 1'b0;
    hard_len();
    chk(msk, 8'h00);
    io(`IO_FAST_CTL_ADDR, 8'h00, 1'b1);
    chk(ird, `FAST_RESET_VAL);
    mm(`MMCR_RESET_STATUS_ADDR, 8'h00, 1'b1);
    chk(mrd, `STA_RESET_VAL);
    mm(12'h0F0, 8'h00, 1'b1);
    chk(mrd, 8'h00);
    mm(`MMCR_RESET_STATUS_ADDR, 8'h01, 1'b0);
    mm(`MMCR_RESET_STATUS_ADDR, 8'h00, 1'b1);
    chk(mrd, 8'h00);
    s0 = soft_seen;
    io(`IO_LEGACY_CMD_ADDR, 8'hFE, 1'b0);
    // idle cycle keeps the two soft pulses apart
    tick(1);
    sdn = 1'b1;
    tick(2);
    sdn = 1'b0;
    io(`IO_FAST_CTL_ADDR, 8'h01, 1'b0);
    io(`IO_FAST_CTL_ADDR, 8'h01, 1'b0);
    io(`IO_FAST_CTL_ADDR, 8'h00, 1'b1);
    chk(ird, 8'h01);
    io(`IO_FAST_CTL_ADDR, 8'h00, 1'b0);
    tick(2);
    chk(8'(soft_seen - s0), 8'h04);
    mm(`MMCR_RESET_STATUS_ADDR, 8'h00, 1'b1);
    chk(mrd, 8'h44);
    // watchdog, debug system reset, software system reset
    for (int k = 0; k < 3; k++)
    begin
      tick(1);
      wd = (k == 0);
      dbg = (k == 1);
      if (k == 2)
        mm(`MMCR_RESET_CFG_ADDR, 8'h01, 1'b0);
      else
        tick(1);
      wd = 1'b0;
      dbg = 1'b0;
      chk({pbr, prst, irr, sft}, 8'h0E);
      hard_len();
      chk(n[7:0], `HARD_RESET_CYCLES);
    end
    mm(`MMCR_RESET_CFG_ADDR, 8'h00, 1'b0);
    mm(`MMCR_RESET_STATUS_ADDR, 8'h00, 1'b1);
    chk(mrd, 8'h5C);
    // software bus reset and bridge pci reset reach only their own pins
    mm(`MMCR_RESET_CFG_ADDR, 8'h02, 1'b0);
    pci = 1'b1;
    tick(1);
    chk({pbr, prst, hrd, sft}, 8'h0C);
    mm(`MMCR_RESET_CFG_ADDR, 8'h00, 1'b0);
    chk({pbr, prst, hrd}, 8'h02);
    pci = 1'b0;
    // pin ignored while disabled, preserving reset once enabled
    prg = 1'b1;
    tick(3);
    chk(hrd, 8'h00);
    prg = 1'b0;
    mm(`MMCR_RESET_CFG_ADDR, 8'h04, 1'b0);
    prg = 1'b1;
    tick(2);
    chk({hrd, sdp}, 8'h03);
    hard_len();
    prg = 1'b0;
    mm(`MMCR_RESET_STATUS_ADDR, 8'h00, 1'b1);
    chk(mrd, 8'h5E);
    // random gate settings through both sources, junk in the data bit 0
    s0 = soft_seen;
    for (int k = 0; k < 6; k++)
    begin
      g = $urandom;
      e = $urandom;
      io(`IO_LEGACY_CMD_ADDR, `LEGACY_CMD_WRITE_OUT, 1'b0);
      io(`IO_LEGACY_DATA_ADDR, {6'h00, e[0], e[1]}, 1'b0);
      io(`IO_FAST_CTL_ADDR, {6'h00, g[0], 1'b0}, 1'b0);
      tick(1);
      chk(msk, !(g[0] | e[0]));
      io(`IO_FAST_CTL_ADDR, 8'h00, 1'b1);
      chk(ird, {6'h00, g[0], 1'b0});
    end
    tick(2);
    chk(8'(soft_seen - s0), 8'h00);
    // power-good restores status and disables the pin
    pok = 1'b0;
    tick(2);
    chk(hrd, 8'h01);
    pok = 1'b1;
    hard_len();
    mm(`MMCR_RESET_STATUS_ADDR, 8'h00, 1'b1);
    chk(mrd, `STA_RESET_VAL);
    mm(`MMCR_RESET_CFG_ADDR, 8'h00, 1'b1);
    chk(mrd, `CFG_RESET_VAL);
    prg = 1'b1;
    tick(3);
    chk(hrd, 8'h00);
    prg = 1'b0;
    chk(8'(soft_bad), 8'h00);
    summarize();
  end
endmodule
